// file: compact_isa_exec.sv
`timescale 1ns/1ps
module compact_isa_exec
   import isa_pkg::*;
(
   input  wire logic        clock,               // core clock, 40 MHz
   input  wire logic        reset,               // async, active high
   input  wire logic        instr_valid,         // instruction offered
   input  wire logic [15:0] instr,               // compressed instruction
   input  wire logic [31:0] instr_addr,          // address of instruction
   output logic             instr_ready,         // instruction taken when valid
   output logic             mem_req,             // word read request
   output logic [31:0]      mem_addr,            // word read address
   input  wire logic [31:0] mem_rdata,           // read data
   input  wire logic        mem_ack,             // read data valid
   output logic             branch_valid,        // one-cycle new flow pulse
   output logic [31:0]      branch_target,       // new flow address
   output logic             compressed_state,    // 1 = compressed state
   output flags_t           program_status_word, // condition flags
   input  wire logic [3:0]  reg_sel,             // debug register select
   output logic [31:0]      reg_value            // debug register value
);
   typedef enum logic [1:0] {st_idle, st_stall, st_load} exec_state_t;

   exec_state_t state;
   logic [31:0] regs [16];
   logic [2:0]  stall_count;
   logic [2:0]  ld_dst;
   logic        accept;
   logic        is_alu;
   logic        is_hi;
   logic        is_ld;
   logic [3:0]  alu_op;
   logic [1:0]  hi_op;
   logic [3:0]  dst_idx;
   logic [3:0]  src_idx;
   logic [31:0] pc_read;
   logic [31:0] dst_val;
   logic [31:0] src_val;
   logic [31:0] ld_addr;
   logic [31:0] alu_res;
   flags_t      alu_flags;
   logic        wr_en;
   logic [31:0] wr_val;
   logic        flags_upd;
   logic        br;
   logic [31:0] br_tgt;
   logic        br_state;
   logic [2:0]  latency;
   logic [2:0]  mult_steps;

   assign is_alu  = (instr[15:10] == FMT_ALU);
   assign is_hi   = (instr[15:10] == FMT_HI);
   assign is_ld   = (instr[15:11] == FMT_LD);
   assign alu_op  = is_hi ? OP_COMPARE : instr[9:6];
   assign hi_op   = instr[9:8];
   assign dst_idx = {is_hi & instr[7], instr[2:0]};
   assign src_idx = {is_hi & instr[6], instr[5:3]};
   assign pc_read = (instr_addr + PC_AHEAD) & ~32'h0000_0001;
   assign dst_val = (dst_idx == PC_IDX) ? pc_read : regs[dst_idx];
   assign src_val = (src_idx == PC_IDX) ? pc_read : regs[src_idx];
   assign ld_addr = (pc_read & ~32'h0000_0002) + {22'h00_0000, instr[7:0], 2'b00};
   assign accept  = instr_valid && (state == st_idle);
   assign instr_ready = (state == st_idle);
   assign reg_value   = (reg_sel == PC_IDX) ? pc_read : regs[reg_sel];

   alu_unit u_alu (
      .op        (alu_op),
      .a         (dst_val),
      .b         (src_val),
      .flags_in  (program_status_word),
      .result    (alu_res),
      .flags_out (alu_flags)
   );

   // multiplier early termination on the destination operand
   always_comb begin
      mult_steps = 3'h4;
      if (dst_val[31:8] == 24'h00_0000 || dst_val[31:8] == 24'hFF_FFFF) begin
         mult_steps = 3'h1;
      end else if (dst_val[31:16] == 16'h0000 || dst_val[31:16] == 16'hFFFF) begin
         mult_steps = 3'h2;
      end else if (dst_val[31:24] == 8'h00 || dst_val[31:24] == 8'hFF) begin
         mult_steps = 3'h3;
      end
   end

   always_comb begin
      wr_en     = 1'b0;
      wr_val    = alu_res;
      flags_upd = 1'b0;
      br        = 1'b0;
      br_tgt    = 32'h0000_0000;
      br_state  = compressed_state;
      latency   = CYC_DP;
      if (is_alu) begin
         flags_upd = 1'b1;
         wr_en = !(alu_op == OP_TEST || alu_op == OP_COMPARE
                   || alu_op == OP_COMPARE_NEG);
         case (alu_op)
            OP_SHL, OP_SHR, OP_SAR, OP_ROTR: latency = CYC_SHIFT_RG;
            OP_MULT:                         latency = CYC_DP + mult_steps;
            default:                        latency = CYC_DP;
         endcase
      end else if (is_hi) begin
         case (hi_op)
            HI_ADD: begin
               wr_en  = 1'b1;
               wr_val = dst_val + src_val;
            end
            HI_COMPARE: flags_upd = 1'b1;
            HI_COPY: begin
               wr_en  = 1'b1;
               wr_val = src_val;
            end
            default: begin
               br       = 1'b1;
               br_tgt   = src_val & ~32'h0000_0001;
               br_state = src_val[0];
               latency  = CYC_PC_WRITE;
            end
         endcase
         // writes to the program counter become a flow change
         if (wr_en && dst_idx == PC_IDX) begin
            wr_en   = 1'b0;
            br      = 1'b1;
            br_tgt  = wr_val & ~32'h0000_0001;
            latency = CYC_PC_WRITE;
         end
      end else if (is_ld) begin
         latency = CYC_LOAD;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 16; i++) begin
            regs[i] <= 32'h0000_0000;
         end
      end else if (accept && wr_en) begin
         regs[dst_idx] <= wr_val;
      end else if (state == st_load && mem_ack) begin
         regs[{1'b0, ld_dst}] <= mem_rdata;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         program_status_word <= '0;
      end else if (accept && flags_upd) begin
         program_status_word <= alu_flags;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         branch_valid     <= 1'b0;
         branch_target    <= 32'h0000_0000;
         compressed_state <= STATE_RESET;
      end else begin
         branch_valid <= accept && br;
         if (accept && br) begin
            branch_target    <= br_tgt;
            compressed_state <= br_state;
         end
      end
   end

   // the load waits as long as memory does; the idle cycle after it mirrors
   // the internal cycle of the 32-bit equivalent
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state       <= st_idle;
         stall_count <= 3'h0;
         mem_req     <= 1'b0;
         mem_addr    <= 32'h0000_0000;
         ld_dst      <= 3'h0;
      end else begin
         case (state)
            st_idle: begin
               if (accept && is_ld) begin
                  state    <= st_load;
                  mem_req  <= 1'b1;
                  mem_addr <= ld_addr;
                  ld_dst   <= instr[10:8];
               end else if (accept && latency > CYC_DP) begin
                  state       <= st_stall;
                  stall_count <= latency - CYC_DP;
               end
            end
            st_load: begin
               if (mem_ack) begin
                  mem_req     <= 1'b0;
                  state       <= st_stall;
                  stall_count <= 3'h1;
               end
            end
            st_stall: begin
               stall_count <= stall_count - 3'h1;
               if (stall_count == 3'h1) begin
                  state <= st_idle;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_zero_flag;
      accept && is_alu |=> program_status_word.z == $past(alu_res == 32'h0000_0000);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

   property p_and_write;
      accept && is_alu && alu_op == OP_AND |=> regs[$past(dst_idx)] == $past(dst_val & src_val);
   endproperty
   a_and_write: assert property (p_and_write) else $error("and result wrong");

   property p_shift_time;
      accept && is_alu && alu_op == OP_SHR |=> !instr_ready ##1 instr_ready;
   endproperty
   a_shift_time: assert property (p_shift_time) else $error("shift timing wrong");

   property p_adc_write;
      accept && is_alu && alu_op == OP_ADC
         |=> regs[$past(dst_idx)]
             == $past(dst_val + src_val + {31'h0000_0000, program_status_word.c});
   endproperty
   a_adc_write: assert property (p_adc_write) else $error("add with carry wrong");

   property p_tst_keep;
      accept && is_alu && alu_op == OP_TEST |=> regs[$past(dst_idx)] == $past(dst_val);
   endproperty
   a_tst_keep: assert property (p_tst_keep) else $error("bit test wrote register");

   property p_cmp_zero;
      accept && is_alu && alu_op == OP_COMPARE
         |=> program_status_word.z == $past(dst_val == src_val);
   endproperty
   a_cmp_zero: assert property (p_cmp_zero) else $error("compare zero flag wrong");

   property p_hi_flags;
      accept && is_hi && hi_op != HI_COMPARE |=> $stable(program_status_word);
   endproperty
   a_hi_flags: assert property (p_hi_flags) else $error("high op changed flags");

   property p_branch_state;
      accept && is_hi && hi_op == HI_BR
         |=> branch_valid && compressed_state == $past(src_val[0])
             ##1 !branch_valid [*2] ##1 instr_ready;
   endproperty
   a_branch_state: assert property (p_branch_state) else $error("state branch wrong");

   property p_load_addr;
      accept && is_ld |=> mem_req && mem_addr[1:0] == 2'b00
         && mem_addr == $past(((instr_addr + PC_AHEAD) & ~32'h0000_0003) + {instr[7:0], 2'b00});
   endproperty
   a_load_addr: assert property (p_load_addr) else $error("load address wrong");

   property p_load_len;
      accept && is_ld |=> !instr_ready [*2];
   endproperty
   a_load_len: assert property (p_load_len) else $error("load too short");

   c_mult: cover property (accept && is_alu && alu_op == OP_MULT);
   c_pc_write: cover property (accept && is_hi && hi_op == HI_COPY && dst_idx == PC_IDX);
   c_load: cover property (state == st_load && mem_ack);
   c_to_wide: cover property (branch_valid && !compressed_state);
endmodule : compact_isa_exec

// file: alu_unit.sv
`timescale 1ns/1ps

package isa_pkg;
   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } flags_t;

   // two-operand group opcodes, instruction bits 9:6
   localparam logic [3:0] OP_AND  = 4'h0;
   localparam logic [3:0] OP_XOR  = 4'h1;
   localparam logic [3:0] OP_SHL         = 4'h2;
   localparam logic [3:0] OP_SHR         = 4'h3;
   localparam logic [3:0] OP_SAR         = 4'h4;
   localparam logic [3:0] OP_ADC         = 4'h5;
   localparam logic [3:0] OP_SUBC        = 4'h6;
   localparam logic [3:0] OP_ROTR        = 4'h7;
   localparam logic [3:0] OP_TEST        = 4'h8;
   localparam logic [3:0] OP_NEGATE      = 4'h9;
   localparam logic [3:0] OP_COMPARE     = 4'hA;
   localparam logic [3:0] OP_COMPARE_NEG = 4'hB;
   localparam logic [3:0] OP_OR          = 4'hC;
   localparam logic [3:0] OP_MULT        = 4'hD;
   localparam logic [3:0] OP_CLEAR       = 4'hE;
   localparam logic [3:0] OP_INVERT      = 4'hF;

   // high-register group operations, instruction bits 9:8
   localparam logic [1:0] HI_ADD     = 2'h0;
   localparam logic [1:0] HI_COMPARE = 2'h1;
   localparam logic [1:0] HI_COPY = 2'h2;
   localparam logic [1:0] HI_BR   = 2'h3;

   // format match values
   localparam logic [5:0] FMT_ALU = 6'h10;
   localparam logic [5:0] FMT_HI  = 6'h11;
   localparam logic [4:0] FMT_LD  = 5'h09;

   localparam logic [3:0]  PC_IDX      = 4'hF;
   localparam logic [31:0] PC_AHEAD    = 32'h0000_0004;
   localparam logic        STATE_RESET = 1'b1;

   // cycle counts of the 32-bit equivalents
   localparam logic [2:0] CYC_DP       = 3'h1;
   localparam logic [2:0] CYC_SHIFT_RG = 3'h2;
   localparam logic [2:0] CYC_PC_WRITE = 3'h3;
   localparam logic [2:0] CYC_LOAD     = 3'h3;
endpackage : isa_pkg

module alu_unit
   import isa_pkg::*;
(
   input  wire logic [3:0]  op,        // two-operand opcode
   input  wire logic [31:0] a,         // destination operand
   input  wire logic [31:0] b,         // source operand
   input  wire flags_t      flags_in,  // current flags
   output logic [31:0]      result,    // operation result
   output flags_t           flags_out  // flags after the operation
);
   always_comb begin
      logic [32:0] sum;
      logic [31:0] x;
      logic [31:0] y;
      logic        ci;
      logic [7:0]  amt;
      logic [4:0]  r;
      logic        sc;
      logic        arith;
      sum   = 33'h0_0000_0000;
      x     = a;
      y     = b;
      ci    = 1'b0;
      amt   = b[7:0];
      r     = b[4:0];
      sc    = flags_in.c;
      arith = 1'b0;
      result = a;
      case (op)
         OP_AND, OP_TEST: result = a & b;
         OP_XOR:          result = a ^ b;
         OP_OR:           result = a | b;
         OP_CLEAR:        result = a & ~b;
         OP_INVERT:       result = ~b;
         OP_MULT:         result = a * b;
         OP_SHL: begin
            if (amt == 8'h00) begin
               result = a;
            end else if (amt < 8'h20) begin
               result = a << amt;
               sc     = a[5'(6'h20 - amt[5:0])];
            end else begin
               result = 32'h0000_0000;
               sc     = (amt == 8'h20) ? a[0] : 1'b0;
            end
         end
         OP_SHR: begin
            if (amt == 8'h00) begin
               result = a;
            end else if (amt < 8'h20) begin
               result = a >> amt;
               sc     = a[r - 5'h01];
            end else begin
               result = 32'h0000_0000;
               sc     = (amt == 8'h20) ? a[31] : 1'b0;
            end
         end
         OP_SAR: begin
            if (amt == 8'h00) begin
               result = a;
            end else if (amt < 8'h20) begin
               result = $signed(a) >>> r;
               sc     = a[r - 5'h01];
            end else begin
               result = {32{a[31]}};
               sc     = a[31];
            end
         end
         OP_ROTR: begin
            // a nonzero multiple of 32 leaves the value but copies bit 31 to carry
            if (amt == 8'h00) begin
               result = a;
            end else begin
               result = (a >> r) | (a << (6'h20 - {1'b0, r}));
               sc     = result[31];
            end
         end
         default: begin
            arith = 1'b1;
            case (op)
               OP_ADC: ci = flags_in.c;
               OP_SUBC: begin
                  y  = ~b;
                  ci = flags_in.c;
               end
               OP_NEGATE: begin
                  x  = 32'h0000_0000;
                  y  = ~b;
                  ci = 1'b1;
               end
               OP_COMPARE: begin
                  y  = ~b;
                  ci = 1'b1;
               end
               default: ci = 1'b0;
            endcase
            sum    = {1'b0, x} + {1'b0, y} + {32'h0000_0000, ci};
            result = sum[31:0];
            sc     = sum[32];
         end
      endcase
      flags_out.n = result[31];
      flags_out.z = (result == 32'h0000_0000);
      flags_out.c = (op == OP_MULT) ? flags_in.c : sc;
      flags_out.v = arith ? ((x[31] == y[31]) && (result[31] != x[31])) : flags_in.v;
   end
endmodule : alu_unit

// file: compact_isa_alu_hireg_pcload_tb_top.sv
`timescale 1ns/1ps
module compact_isa_alu_hireg_pcload_tb_top
   import isa_pkg::*;
;
   localparam int LIMIT = 5000;
   logic        clock;
   logic        reset;
   logic        instr_valid;
   logic [15:0] instr;
   logic [31:0] instr_addr;
   logic        instr_ready;
   logic        mem_req;
   logic [31:0] mem_addr;
   logic [31:0] mem_rdata;
   logic        mem_ack;
   logic        branch_valid;
   logic [31:0] branch_target;
   logic        compressed_state;
   flags_t      psw;
   flags_t      ef;
   logic [3:0]  reg_sel;
   logic [31:0] reg_value;
   logic [31:0] mem_word;
   logic [31:0] exp_maddr;
   logic        bv;
   logic [31:0] bt;
   int          lat;
   int          n_mismatch;
   int          checked;
   int          cycles;

   compact_isa_exec i_dut (
      .clock               (clock),
      .reset               (reset),
      .instr_valid         (instr_valid),
      .instr               (instr),
      .instr_addr          (instr_addr),
      .instr_ready         (instr_ready),
      .mem_req             (mem_req),
      .mem_addr            (mem_addr),
      .mem_rdata           (mem_rdata),
      .mem_ack             (mem_ack),
      .branch_valid        (branch_valid),
      .branch_target       (branch_target),
      .compressed_state    (compressed_state),
      .program_status_word (psw),
      .reg_sel             (reg_sel),
      .reg_value           (reg_value)
   );

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_flags(input flags_t got, input flags_t exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_flags

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_mismatch++;
         conclude();
      end
   end

   // memory side: acks in the same cycle the request rises; released data shows the inverse
   always @(posedge clock) begin
      #1;
      if (mem_req === 1'b1 && mem_ack === 1'b0) begin
         cmp_word(mem_addr, exp_maddr);
         mem_ack = 1'b1;
         mem_rdata = mem_word;
      end else begin
         mem_ack = 1'b0;
         mem_rdata = ~mem_word;
      end
   end

   function automatic logic [31:0] ref_alu(input logic [3:0] op, input logic [31:0] a,
                                           input logic [31:0] b, inout flags_t f);
      logic [32:0] s;
      logic [31:0] r;
      logic [31:0] x;
      logic [31:0] y;
      logic [4:0]  k;
      logic        cin;
      k = b[4:0];
      case (op)
         OP_AND, OP_TEST: r = a & b;
         OP_XOR:    r = a ^ b;
         OP_OR:     r = a | b;
         OP_CLEAR:  r = a & ~b;
         OP_INVERT: r = ~b;
         OP_MULT:   r = a * b;
         OP_SHL: begin
            r = a << k;
            f.c = a[32 - k];
         end
         OP_SHR: begin
            r = a >> k;
            f.c = a[k - 1];
         end
         OP_SAR: begin
            r = $signed(a) >>> k;
            f.c = a[k - 1];
         end
         OP_ROTR: begin
            r = (a >> k) | (a << (32 - k));
            f.c = a[k - 1];
         end
         default: begin
            x = (op == OP_NEGATE) ? 32'h0000_0000 : a;
            y = (op == OP_ADC || op == OP_COMPARE_NEG) ? b : ~b;
            cin = (op == OP_ADC || op == OP_SUBC) ? f.c : (op != OP_COMPARE_NEG);
            s = {1'b0, x} + {1'b0, y} + {32'h0000_0000, cin};
            r = s[31:0];
            f.c = s[32];
            f.v = (x[31] == y[31]) && (r[31] != x[31]);
         end
      endcase
      f.n = r[31];
      f.z = (r == 32'h0000_0000);
      return r;
   endfunction : ref_alu

   task automatic chk_reg(input logic [3:0] idx, input logic [31:0] exp);
      reg_sel = idx;
      #1;
      cmp_word(reg_value, exp);
   endtask : chk_reg

   // extra edge at the end keeps valid from being driven twice in one step
   task automatic issue(input logic [15:0] ins);
      instr_valid = 1'b1;
      instr = ins;
      @(posedge clock);
      #1;
      instr_valid = 1'b0;
      bv = branch_valid;
      bt = branch_target;
      lat = 1;
      while (instr_ready !== 1'b1 && lat < 40) begin
         @(posedge clock);
         #1;
         lat++;
      end
      @(posedge clock);
      #1;
   endtask : issue

   task automatic load(input logic [2:0] rd, input logic [7:0] w8, input logic [31:0] val);
      mem_word = val;
      exp_maddr = ((instr_addr + 32'h0000_0004) & ~32'h0000_0003) + {22'h0, w8, 2'b00};
      issue({FMT_LD, rd, w8});
      cmp_word(32'(lat), {29'h0, CYC_LOAD});
      chk_reg({1'b0, rd}, val);
   endtask : load

   task automatic do_reset;
      reset = 1'b1;
      repeat (16) @(posedge clock);
      #1;
      reset = 1'b0;
      ef = '0;
      cmp_word({28'h0, instr_ready, mem_req, branch_valid, compressed_state}, 32'h0000_0009);
      cmp_flags(psw, ef);
      for (int i = 0; i < 15; i++) begin
         chk_reg(4'(i), 32'h0000_0000);
      end
      $display("test reset done");
   endtask : do_reset

   task automatic t_alu;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] r;
      logic [31:0] el;
      a = 32'h8000_00F9;
      b = 32'h0000_0004;
      for (int i = 0; i < 16; i++) begin
         load(3'h1, 8'h10, a);
         load(3'h2, 8'h11, b);
         r = ref_alu(4'(i), a, b, ef);
         issue({FMT_ALU, 4'(i), 3'h2, 3'h1});
         cmp_flags(psw, ef);
         chk_reg(4'h1, (i == 8 || i == 10 || i == 11) ? a : r);
         // destination top byte is neither 00 nor ff, so multiply takes four steps
         el = (i == 13) ? 32'h0000_0005 : {29'h0, CYC_DP};
         if (i == 2 || i == 3 || i == 4 || i == 7) begin
            el = {29'h0, CYC_SHIFT_RG};
         end
         cmp_word(32'(lat), el);
         chk_reg(4'h1, (i == 8 || i == 10 || i == 11) ? a : r);
      end
      $display("test alu done");
   endtask : t_alu

   task automatic t_high;
      load(3'h2, 8'hFF, 32'h7000_0010);
      issue({FMT_HI, HI_COPY, 1'b1, 1'b0, 3'h2, 3'h1});
      chk_reg(4'h9, 32'h7000_0010);
      issue({FMT_HI, HI_ADD, 1'b1, 1'b0, 3'h2, 3'h1});
      chk_reg(4'h9, 32'hE000_0020);
      cmp_flags(psw, ef);
      issue({FMT_HI, HI_COMPARE, 1'b1, 1'b0, 3'h2, 3'h1});
      void'(ref_alu(OP_COMPARE, 32'hE000_0020, 32'h7000_0010, ef));
      cmp_flags(psw, ef);
      issue({FMT_HI, HI_COPY, 1'b0, 1'b1, 3'h1, 3'h3});
      chk_reg(4'h3, 32'hE000_0020);
      instr_addr = 32'h0000_0206;
      issue({FMT_HI, HI_COPY, 1'b0, 1'b1, 3'h7, 3'h4});
      chk_reg(4'h4, 32'h0000_020A);
      cmp_flags(psw, ef);
      $display("test high done");
   endtask : t_high

   task automatic t_branch;
      load(3'h5, 8'h00, 32'h0000_1000);
      load(3'h2, 8'h01, 32'h0000_2235);
      issue({FMT_HI, HI_COPY, 1'b1, 1'b0, 3'h2, 3'h2});
      // branch source is never register 15, so alignment of the pc never matters
      issue({FMT_HI, HI_BR, 1'b0, 1'b1, 3'h2, 3'h0});
      cmp_word({31'h0, bv}, 32'h0000_0001);
      cmp_word(bt, 32'h0000_2234);
      cmp_word({31'h0, compressed_state}, 32'h0000_0001);
      issue({FMT_HI, HI_BR, 1'b0, 1'b0, 3'h5, 3'h0});
      cmp_word({31'h0, bv}, 32'h0000_0001);
      cmp_word(bt, 32'h0000_1000);
      cmp_word({31'h0, compressed_state}, 32'h0000_0000);
      cmp_word(32'(lat), {29'h0, CYC_PC_WRITE});
      $display("test branch done");
   endtask : t_branch

   initial begin
      reset = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0000;
      instr_addr = 32'h0000_0102;
      mem_ack = 1'b0;
      mem_rdata = 32'h0000_0000;
      mem_word = 32'h0000_0000;
      exp_maddr = 32'h0000_0000;
      reg_sel = 4'h0;
      n_mismatch = 0;
      checked = 0;
      cycles = 0;
      do_reset();
      t_alu();
      t_high();
      t_branch();
      // second reset must bring back compressed state and cleared registers
      do_reset();
      conclude();
   end
endmodule : compact_isa_alu_hireg_pcload_tb_top
